// ---- pkg/sst_pkg.sv ----
`default_nettype none
// ****************************************************************
// socket state tracker: shared constants and types
// ****************************************************************
package sst_pkg;

  localparam int ADDR_W  = 8;   // register address width
  localparam int DATA_W  = 32;  // register data width
  localparam int PROTO_W = 4;   // protocol select field width
  localparam int CMD_W   = 8;   // command code width
  localparam int IP_W    = 32;  // destination ip width

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_PROTO   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CMD     = 8'h04;
  localparam logic [ADDR_W-1:0] REG_DEST_IP = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATE   = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_FLAGS   = 8'h10;

  // protocol select codes
  localparam logic [PROTO_W-1:0] PROTO_NONE      = 4'h0;
  localparam logic [PROTO_W-1:0] PROTO_TCP       = 4'h1;
  localparam logic [PROTO_W-1:0] PROTO_UDP       = 4'h2;
  localparam logic [PROTO_W-1:0] PROTO_RAW_IP    = 4'h3;
  localparam logic [PROTO_W-1:0] PROTO_RAW_FRAME = 4'h4;
  localparam logic [PROTO_W-1:0] PROTO_PPPOE     = 4'h5;

  // command codes
  localparam logic [CMD_W-1:0] CMD_OPEN       = 8'h01;
  localparam logic [CMD_W-1:0] CMD_LISTEN     = 8'h02;
  localparam logic [CMD_W-1:0] CMD_CONNECT    = 8'h04;
  localparam logic [CMD_W-1:0] CMD_DISCONNECT = 8'h08;
  localparam logic [CMD_W-1:0] CMD_CLOSE      = 8'h10;
  localparam logic [CMD_W-1:0] CMD_SEND       = 8'h20;
  localparam logic [CMD_W-1:0] CMD_RECV       = 8'h40;

  // event flag register layout and reset
  localparam int                FLAG_TIMEOUT = 0;
  localparam logic [DATA_W-1:0] RESET_ZERO   = 32'h0000_0000;

  // socket state codes
  typedef enum logic [7:0] {
    st_closed           = 8'h00,
    st_resolving        = 8'h01,
    st_tcp_initial      = 8'h13,
    st_listening        = 8'h14,
    st_request_sent     = 8'h15,
    st_request_received = 8'h16,
    st_connected        = 8'h17,
    st_teardown_wait    = 8'h18,
    st_linger_wait      = 8'h1b,
    st_half_closed      = 8'h1c,
    st_final_ack_wait   = 8'h1d,
    st_datagram_open    = 8'h22,
    st_raw_ip_open      = 8'h32,
    st_raw_frame_open   = 8'h42,
    st_pppoe_open       = 8'h5f
  } sst_state_e;

endpackage
`default_nettype wire

// ---- pkg/sst_cache_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// link between tracker and resolved-address cache
// ****************************************************************
interface sst_cache_if;
  import sst_pkg::*;
  logic [IP_W-1:0] query_ip;  // current destination ip
  logic            store;     // pulse: remember query_ip as resolved
  logic            hit;       // query_ip equals last resolved ip
  modport owner (output query_ip, output store, input hit);
  modport cache (input query_ip, input store, output hit);
endinterface
`default_nettype wire

// ---- hdl/sst_addr_cache.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// last resolved destination address
// ****************************************************************
module sst_addr_cache
  import sst_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst_n,
  input  wire logic     ce,
  sst_cache_if.cache    cif
);

  logic [IP_W-1:0] resolved_q;  // address of last successful resolution
  logic            valid_q;     // resolved_q holds a real address

  // remember the address once resolution succeeds
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      resolved_q <= RESET_ZERO;
      valid_q    <= 1'b0;
    end
    else if (ce && cif.store)
    begin
      resolved_q <= cif.query_ip;
      valid_q    <= 1'b1;
    end
  end

  // unchanged destination means stored hardware address is reusable
  assign cif.hit = valid_q && (resolved_q == cif.query_ip);

endmodule
`default_nettype wire

// ---- hdl/sst_socket_tracker.sv ----
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// socket state tracker
// ****************************************************************
module sst_socket_tracker
  import sst_pkg::*;
#(
  parameter int SOCKET_ID = 0  // socket number; zero allows frame modes
)
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire logic [ADDR_W-1:0]  reg_addr,
  input  wire logic [DATA_W-1:0]  reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output var  logic [DATA_W-1:0]  reg_rdata,
  input  wire logic               ev_syn_rx,
  input  wire logic               ev_synack_sent,
  input  wire logic               ev_synack_rx,
  input  wire logic               ev_fin_rx,
  input  wire logic               ev_teardown_done,
  input  wire logic               ev_resolve_reply,
  input  wire logic               resolution_timeout,
  input  wire logic               transport_timeout,
  output var  logic [7:0]         socket_state_reg,
  output var  logic               timeout_flag,
  output var  logic               req_resolve,
  output var  logic               req_syn,
  output var  logic               req_fin,
  output var  logic               req_data_send,
  output var  logic               req_recv_ack
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  localparam bit IS_SOCKET0 = (SOCKET_ID == 0);  // frame modes allowed

  sst_state_e          state_q;      // current socket state
  sst_state_e          state_d;      // next socket state
  sst_state_e          prev_q;       // state to resume after resolving
  sst_state_e          prev_d;       // next resume state
  logic [PROTO_W-1:0]  proto_q;      // socket_protocol_select
  logic [IP_W-1:0]     dest_ip_q;    // dest_ip_reg
  logic                flag_q;       // sticky timeout flag
  logic                flag_set;     // a timeout hits this socket
  logic                flag_clr;     // software write-one-to-clear
  logic                cmd_wr;       // command register written
  logic [CMD_W-1:0]    cmd_code;     // command being issued
  logic                tcp_active;   // state that a transport timeout ends
  logic                resolve_d;    // next resolve request
  logic                syn_d;        // next syn request
  logic                fin_d;        // next fin request
  logic                send_d;       // next data send request
  logic                recv_d;       // next receive ack
  logic                store_d;      // remember resolved address

  sst_cache_if cif ();

  // ****************************************************************
  // resolved address cache
  // ****************************************************************
  sst_addr_cache u_cache (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .cif   (cif)
  );

  assign cif.query_ip = dest_ip_q;
  assign cif.store    = store_d;

  // ****************************************************************
  // command and flag decode
  // ****************************************************************
  assign cmd_wr   = reg_wr && (reg_addr == REG_CMD);
  assign cmd_code = reg_wdata[CMD_W-1:0];
  assign flag_clr = reg_wr && (reg_addr == REG_FLAGS) && reg_wdata[FLAG_TIMEOUT];

  // tcp states that a transport timeout tears down
  assign tcp_active = (state_q == st_listening) || (state_q == st_request_received)
                   || (state_q == st_request_sent) || (state_q == st_connected)
                   || (state_q == st_half_closed) || (state_q == st_teardown_wait)
                   || (state_q == st_linger_wait) || (state_q == st_final_ack_wait);

  // timeout flag cause
  assign flag_set = (transport_timeout && tcp_active)
                 || (resolution_timeout && (state_q == st_resolving));

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    state_d   = state_q;
    prev_d    = prev_q;
    resolve_d = 1'b0;
    syn_d     = 1'b0;
    fin_d     = 1'b0;
    send_d    = 1'b0;
    recv_d    = 1'b0;
    store_d   = 1'b0;
    if (cmd_wr && (cmd_code == CMD_CLOSE))
    begin
      // close wins over everything
      state_d = st_closed;
    end
    else if (transport_timeout && tcp_active)
    begin
      state_d = st_closed;
    end
    else if (resolution_timeout && (state_q == st_resolving))
    begin
      // datagram sockets resume, tcp sockets close
      if (prev_q == st_tcp_initial)
      begin
        state_d = st_closed;
      end
      else
      begin
        state_d = prev_q;
      end
    end
    else if (cmd_wr)
    begin
      case (cmd_code)
        CMD_OPEN:
        begin
          // open only from closed, by protocol
          if (state_q == st_closed)
          begin
            if (proto_q == PROTO_TCP)
            begin
              state_d = st_tcp_initial;
            end
            else if (proto_q == PROTO_UDP)
            begin
              state_d = st_datagram_open;
            end
            else if (proto_q == PROTO_RAW_IP)
            begin
              state_d = st_raw_ip_open;
            end
            else if ((proto_q == PROTO_RAW_FRAME) && IS_SOCKET0)
            begin
              state_d = st_raw_frame_open;
            end
            else if ((proto_q == PROTO_PPPOE) && IS_SOCKET0)
            begin
              state_d = st_pppoe_open;
            end
          end
        end
        CMD_LISTEN:
        begin
          // server side from the initial state only
          if (state_q == st_tcp_initial)
          begin
            state_d = st_listening;
          end
        end
        CMD_CONNECT:
        begin
          // client side always resolves first
          if (state_q == st_tcp_initial)
          begin
            state_d   = st_resolving;
            prev_d    = st_tcp_initial;
            resolve_d = 1'b1;
          end
        end
        CMD_DISCONNECT:
        begin
          // graceful teardown where a connection exists
          if (state_q == st_connected)
          begin
            state_d = st_teardown_wait;
            fin_d   = 1'b1;
          end
          else if (state_q == st_half_closed)
          begin
            state_d = st_final_ack_wait;
            fin_d   = 1'b1;
          end
          else if (!tcp_active || (state_q == st_listening))
          begin
            state_d = st_closed;
          end
        end
        CMD_SEND:
        begin
          // datagram send resolves only on a new destination
          if ((state_q == st_datagram_open) || (state_q == st_raw_ip_open))
          begin
            if (cif.hit)
            begin
              send_d = 1'b1;
            end
            else
            begin
              state_d   = st_resolving;
              prev_d    = state_q;
              resolve_d = 1'b1;
            end
          end
          else if ((state_q == st_connected) || (state_q == st_half_closed)
                || (state_q == st_raw_frame_open) || (state_q == st_pppoe_open))
          begin
            send_d = 1'b1;
          end
        end
        CMD_RECV:
        begin
          // acknowledge only where data flows
          if ((state_q == st_connected) || (state_q == st_half_closed)
           || (state_q == st_datagram_open) || (state_q == st_raw_ip_open)
           || (state_q == st_raw_frame_open) || (state_q == st_pppoe_open))
          begin
            recv_d = 1'b1;
          end
        end
        default:
        begin
          state_d = state_q;
        end
      endcase
    end
    else
    begin
      // packet events from the network side
      case (state_q)
        st_listening:
        begin
          if (ev_syn_rx)
          begin
            state_d = st_request_received;
          end
        end
        st_request_received:
        begin
          if (ev_synack_sent)
          begin
            state_d = st_connected;
          end
        end
        st_request_sent:
        begin
          if (ev_synack_rx)
          begin
            state_d = st_connected;
          end
        end
        st_resolving:
        begin
          if (ev_resolve_reply)
          begin
            store_d = 1'b1;
            if (prev_q == st_tcp_initial)
            begin
              state_d = st_request_sent;
              syn_d   = 1'b1;
            end
            else
            begin
              state_d = prev_q;
              send_d  = 1'b1;
            end
          end
        end
        st_connected:
        begin
          if (ev_fin_rx)
          begin
            state_d = st_half_closed;
          end
        end
        st_teardown_wait:
        begin
          if (ev_teardown_done)
          begin
            state_d = st_closed;
          end
          else if (ev_fin_rx)
          begin
            state_d = st_linger_wait;
          end
        end
        st_linger_wait, st_final_ack_wait:
        begin
          if (ev_teardown_done)
          begin
            state_d = st_closed;
          end
        end
        default:
        begin
          state_d = state_q;
        end
      endcase
    end
  end

  // ****************************************************************
  // state registers
  // ****************************************************************
  // socket state; software has no write path here
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= st_closed;
      prev_q  <= st_closed;
    end
    else if (ce)
    begin
      state_q <= state_d;
      prev_q  <= prev_d;
    end
  end

  // requests to the packet engine, one cycle each
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      req_resolve   <= 1'b0;
      req_syn       <= 1'b0;
      req_fin       <= 1'b0;
      req_data_send <= 1'b0;
      req_recv_ack  <= 1'b0;
    end
    else if (ce)
    begin
      req_resolve   <= resolve_d;
      req_syn       <= syn_d;
      req_fin       <= fin_d;
      req_data_send <= send_d;
      req_recv_ack  <= recv_d;
    end
  end

  // sticky timeout flag; a new timeout beats the clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      flag_q <= 1'b0;
    end
    else if (ce)
    begin
      if (flag_set)
      begin
        flag_q <= 1'b1;
      end
      else if (flag_clr)
      begin
        flag_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // register bus
  // ****************************************************************
  // software-written configuration
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      proto_q   <= PROTO_NONE;
      dest_ip_q <= RESET_ZERO;
    end
    else if (ce && reg_wr)
    begin
      if (reg_addr == REG_PROTO)
      begin
        proto_q <= reg_wdata[PROTO_W-1:0];
      end
      else if (reg_addr == REG_DEST_IP)
      begin
        dest_ip_q <= reg_wdata[IP_W-1:0];
      end
    end
  end

  // read data in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= RESET_ZERO;
    end
    else if (ce)
    begin
      reg_rdata <= RESET_ZERO;
      if (reg_rd)
      begin
        if (reg_addr == REG_PROTO)
        begin
          reg_rdata[PROTO_W-1:0] <= proto_q;
        end
        else if (reg_addr == REG_DEST_IP)
        begin
          reg_rdata[IP_W-1:0] <= dest_ip_q;
        end
        else if (reg_addr == REG_STATE)
        begin
          reg_rdata[7:0] <= state_q;
        end
        else if (reg_addr == REG_FLAGS)
        begin
          reg_rdata[FLAG_TIMEOUT] <= flag_q;
        end
      end
    end
  end

  assign socket_state_reg = state_q;
  assign timeout_flag     = flag_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_close_cmd;
    ce && cmd_wr && (cmd_code == CMD_CLOSE);
  endsequence

  sequence s_connect_start;
    ce && cmd_wr && (cmd_code == CMD_CONNECT) && (state_q == st_tcp_initial);
  endsequence

  a_close_forces: assert property (@(posedge clk) disable iff (!rst_n)
    s_close_cmd |=> (state_q == st_closed))
    else $error("close command did not close socket");

  a_open_tcp: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && cmd_wr && (cmd_code == CMD_OPEN) && (state_q == st_closed)
     && (proto_q == PROTO_TCP)) |=> (state_q == st_tcp_initial))
    else $error("tcp open did not reach initial state");

  a_connect_path: assert property (@(posedge clk) disable iff (!rst_n)
    s_connect_start |=> ((state_q == st_resolving) && req_resolve && (prev_q == st_tcp_initial)))
    else $error("connect did not start resolution");

  a_reply_to_syn: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && (state_q == st_resolving) && (prev_q == st_tcp_initial) && ev_resolve_reply
     && !cmd_wr && !resolution_timeout)
    |=> ((state_q == st_request_sent) && req_syn))
    else $error("resolution reply did not send syn");

  a_fin_half: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && (state_q == st_connected) && ev_fin_rx && !cmd_wr && !transport_timeout)
    |=> (state_q == st_half_closed))
    else $error("peer fin did not half close");

  a_frame_only0: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !IS_SOCKET0 && cmd_wr && (cmd_code == CMD_OPEN)
     && ((proto_q == PROTO_RAW_FRAME) || (proto_q == PROTO_PPPOE))
     && !transport_timeout && !resolution_timeout)
    |=> $stable(state_q))
    else $error("frame mode opened on nonzero socket");

  a_resolve_fail: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && (state_q == st_resolving) && (prev_q == st_datagram_open) && resolution_timeout
     && !(cmd_wr && (cmd_code == CMD_CLOSE)))
    |=> ((state_q == st_datagram_open) && flag_q))
    else $error("resolution timeout did not resume datagram");

  a_same_dest: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && cmd_wr && (cmd_code == CMD_SEND) && (state_q == st_datagram_open) && cif.hit
     && !transport_timeout)
    |=> (req_data_send && !req_resolve && (state_q == st_datagram_open)))
    else $error("resolution repeated for unchanged destination");

  a_listen_only: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && cmd_wr && (cmd_code == CMD_LISTEN) && (state_q != st_tcp_initial)
     && !transport_timeout && !resolution_timeout)
    |=> $stable(state_q))
    else $error("listen accepted outside initial state");

  a_legal_code: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q inside {st_closed, st_resolving, st_tcp_initial, st_listening,
     st_request_sent, st_request_received, st_connected, st_teardown_wait,
     st_linger_wait, st_half_closed, st_final_ack_wait, st_datagram_open,
     st_raw_ip_open, st_raw_frame_open, st_pppoe_open}))
    else $error("state holds an unlisted code");

endmodule
`default_nettype wire

// ---- verification/sst_peer_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// remote peer: answers resolution and connect requests
// ****************************************************************
module sst_peer_model
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic answer,
  input  wire logic slow,
  input  wire logic req_resolve,
  input  wire logic req_syn,
  output logic      ev_resolve_reply,
  output logic      ev_synack_rx
);
  logic [3:0] rs_q;  // resolution request delay line
  logic [3:0] sy_q;  // connection request delay line
  // delay lines; a silent peer never answers
  always_ff @(posedge clk)
    if (!rst_n)
    begin
      rs_q <= '0;
      sy_q <= '0;
    end
    else
    begin
      rs_q <= {rs_q[2:0], req_resolve & answer};
      sy_q <= {sy_q[2:0], req_syn & answer};
    end
  // prompt peer answers after one cycle, slow after four
  assign ev_resolve_reply = slow ? rs_q[3] : rs_q[0];
  assign ev_synack_rx     = slow ? sy_q[3] : sy_q[0];
endmodule
`default_nettype wire

// ---- verification/sst_socket_tracker_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module sst_socket_tracker_bench;
  import sst_pkg::*;
  logic              clk = 0;
  logic              rst_n = 0;
  logic              wr = 0;
  logic              rd = 0;
  logic              answer = 1;  // peer answers requests
  logic              slow = 0;    // peer answers late
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [5:0]        ev = '0;     // syn, synack sent, fin, done, res to, tr to
  logic [DATA_W-1:0] rdata;
  logic [7:0]        state;
  logic              flag, rs_req, syn_req, send_req, reply, synack;
  logic              fin_req, ack_req;
  logic [7:0]        state1;      // state of a nonzero socket
  int                miscompares = 0;
  int                checks_done = 0;
  localparam logic [PROTO_W-1:0] PR [5] = '{PROTO_TCP, PROTO_UDP, PROTO_RAW_IP,
                                            PROTO_RAW_FRAME, PROTO_PPPOE};
  localparam logic [7:0] OPN [5] = '{8'h13, 8'h22, 8'h32, 8'h42, 8'h5f};
  always #2 clk = ~clk;
  sst_socket_tracker sst_socket_tracker_i (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .ev_syn_rx(ev[0]), .ev_synack_sent(ev[1]), .ev_synack_rx(synack), .ev_fin_rx(ev[2]),
    .ev_teardown_done(ev[3]), .ev_resolve_reply(reply), .resolution_timeout(ev[4]),
    .transport_timeout(ev[5]), .socket_state_reg(state), .timeout_flag(flag),
    .req_resolve(rs_req), .req_syn(syn_req), .req_fin(fin_req), .req_data_send(send_req),
    .req_recv_ack(ack_req));
  // socket one sees the same traffic; frame modes must stay refused there
  sst_socket_tracker #(.SOCKET_ID(1)) sst_socket_tracker_i1 (.clk(clk), .rst_n(rst_n),
    .ce(1'b1), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(),
    .ev_syn_rx(ev[0]), .ev_synack_sent(ev[1]), .ev_synack_rx(synack), .ev_fin_rx(ev[2]),
    .ev_teardown_done(ev[3]), .ev_resolve_reply(reply), .resolution_timeout(ev[4]),
    .transport_timeout(ev[5]), .socket_state_reg(state1), .timeout_flag(),
    .req_resolve(), .req_syn(), .req_fin(), .req_data_send(), .req_recv_ack());
  sst_peer_model sst_peer_model_i (.clk(clk), .rst_n(rst_n), .answer(answer),
    .slow(slow), .req_resolve(rs_req), .req_syn(syn_req), .ev_resolve_reply(reply),
    .ev_synack_rx(synack));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  // one bus cycle, then settle just past the taking edge
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    #1;
  endtask
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    bus(0, a, '0);
    cmp("reg_rdata", e, rdata);
  endtask
  task automatic cmd(input logic [CMD_W-1:0] c);
    bus(1, REG_CMD, {24'h0, c});
  endtask
  task automatic st(input logic [7:0] e);
    cmp("socket_state_reg", {24'h0, e}, {24'h0, state});
  endtask
  // bounded wait for the peer to move the state
  task automatic waitst(input logic [7:0] e);
    repeat (12) if (state !== e) #4;
    st(e);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1;
    @(posedge clk);
    ev <= '0;
    #1;
  endtask
  task automatic summarize;
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    rdchk(REG_STATE, 32'h0);
    bus(1, REG_STATE, 32'h17);
    st(8'h00);
    rdchk(8'h1c, 32'h0);
    cmd(CMD_LISTEN);
    st(8'h00);
  endtask
  task automatic t_opens;
    for (int i = 0; i < 5; i++)
    begin
      bus(1, REG_PROTO, {28'h0, PR[i]});
      cmd(CMD_OPEN);
      st(OPN[i]);
      cmp("socket_state_reg_1", {24'h0, (i < 3) ? OPN[i] : 8'h00}, {24'h0, state1});
      cmd(CMD_CLOSE);
      st(8'h00);
    end
  endtask
  task automatic t_server;
    bus(1, REG_PROTO, {28'h0, PROTO_TCP});
    cmd(CMD_OPEN);
    cmd(CMD_LISTEN);
    st(8'h14);
    pulse(0);
    st(8'h16);
    pulse(1);
    st(8'h17);
    cmd(CMD_SEND);
    cmp("req_data_send", 1, send_req);
    cmd(CMD_RECV);
    cmp("req_recv_ack", 1, ack_req);
    pulse(2);
    st(8'h1c);
    cmd(CMD_DISCONNECT);
    st(8'h1d);
    cmp("req_fin", 1, fin_req);
    pulse(5);
    st(8'h00);
    rdchk(REG_FLAGS, 32'h1);
    bus(1, REG_FLAGS, 32'h1);
    rdchk(REG_FLAGS, 32'h0);
  endtask
  task automatic t_client;
    slow = 1;
    cmd(CMD_OPEN);
    cmd(CMD_SEND);
    cmp("req_data_send", 0, send_req);
    cmd(CMD_RECV);
    cmp("req_recv_ack", 0, ack_req);
    cmd(CMD_CONNECT);
    st(8'h01);
    cmp("req_resolve", 1, rs_req);
    waitst(8'h15);
    waitst(8'h17);
    cmd(CMD_DISCONNECT);
    st(8'h18);
    cmp("req_fin", 1, fin_req);
    pulse(2);
    st(8'h1b);
    pulse(3);
    st(8'h00);
    answer = 0;
    cmd(CMD_OPEN);
    cmd(CMD_CONNECT);
    pulse(4);
    st(8'h00);
    cmp("timeout_flag", 1, flag);
    bus(1, REG_FLAGS, 32'h1);
    answer = 1;
    slow = 0;
  endtask
  task automatic t_dgram;
    bus(1, REG_PROTO, {28'h0, PROTO_UDP});
    bus(1, REG_DEST_IP, 32'h0a00_0001);
    cmd(CMD_OPEN);
    answer = 0;
    cmd(CMD_SEND);
    st(8'h01);
    pulse(4);
    st(8'h22);
    cmp("timeout_flag", 1, flag);
    answer = 1;
    cmd(CMD_SEND);
    waitst(8'h22);
    cmd(CMD_SEND);
    st(8'h22);
    cmp("req_data_send", 1, send_req);
    cmd(CMD_CLOSE);
    st(8'h00);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    t_reset();
    t_opens();
    t_server();
    t_client();
    t_dgram();
    summarize();
  end
  // watchdog against a hung handshake
  initial
  begin
    repeat (3000) @(posedge clk);
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
